//--- hdl/prcd_decoder.sv
// Command decoder, setup register, sequencer stack and result readback.
// Assumes all inputs are synchronous to clk and the converter core
// answers every conv_start with one conv_done carrying both results.
`timescale 1ns/1ps
`default_nettype none
module prcd_decoder
  import prcd_pkg::*;
#(
  parameter int unsigned LAYERS = PRCD_LAYERS
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cmd_write,
  input  wire logic [15:0] data_lines_in,
  input  wire logic        read_active,
  output logic      [15:0] data_lines_out,
  output logic             data_lines_oe,
  input  wire logic        software_mode,
  input  wire logic        selftest_fault_in,
  input  wire logic [7:0]  manual_pair,
  input  wire logic        conversion_trigger,
  input  wire logic        conv_done,
  input  wire logic [15:0] result_a,
  input  wire logic [15:0] result_b,
  output logic             conv_start,
  output logic      [7:0]  conv_pair,
  output logic             conv_busy,
  output logic      [2:0]  oversample_ratio,
  output logic             burst_enable,
  output logic             sequencer_enable,
  output logic             status_append_enable,
  output logic             selftest_fault_flag
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [6:0]              setup;
    logic                    fault;
    logic [LAYERS-1:0][8:0]  stack;
    logic                    res_mode;
    logic [4:0]              rd_sel;
    logic                    rd_stack;
    logic [6:0]              rd_ptr;
    logic                    rd_prev;
    logic [LAYERS-1:0][31:0] res;
    logic [5:0]              cnt;
    logic [4:0]              layer;
    logic [7:0]              crc;
    logic [7:0]              last_pair;
    prcd_conv_e              conv;
    logic [15:0]             dout;
    logic                    oe;
    logic                    start;
    logic [7:0]              pair;
    logic [2:0]              os_eff;
    logic                    burst_eff;
    logic                    seq_eff;
    logic                    stat_eff;
    logic                    busy;
    logic                    init;
  } prcd_state_s;

  prcd_state_s st_reg;
  prcd_state_s st_next;
  wire logic [LAYERS-1:0][8:0] stack_init;
  logic [7:0]             crc_new;

  // ****************************************************************
  // Stack reset image: first layers walk pairs 0..7, the rest zero
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < LAYERS; gi++) begin : g_init
      if (gi < PRCD_INIT_PAIRS) begin : g_pair
        assign stack_init[gi] = {1'b0, 4'(gi), 4'(gi)};
      end else begin : g_zero
        assign stack_init[gi] = PRCD_LAYER_ZERO;
      end
    end
  endgenerate

  prcd_crc_pair u_crc (
    .crc_in  (st_reg.crc),
    .data_a  (result_a),
    .data_b  (result_b),
    .crc_out (crc_new)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic              wr_flag;
  logic              sel_stack;
  logic [4:0]        sel_low;
  logic [8:0]        wdata;
  logic [15:0]       word;
  logic [6:0]        nwords;
  logic [8:0]        cur_layer;
  logic              sw_burst;
  logic              sw_seq;
  logic              sw_stat;

  always_comb begin
    st_next   = st_reg;
    wr_flag   = data_lines_in[PRCD_WR_BIT];
    sel_stack = data_lines_in[PRCD_STACK_BIT];
    sel_low   = data_lines_in[PRCD_SEL_HI-1:PRCD_SEL_LO];
    wdata     = data_lines_in[PRCD_DATA_W-1:0];
    word      = 16'h0000;
    nwords    = {st_reg.cnt, 1'b0};
    cur_layer = st_reg.stack[st_reg.layer];
    sw_burst  = software_mode & st_reg.setup[PRCD_BURST_BIT];
    sw_seq    = software_mode & st_reg.setup[PRCD_SEQ_BIT];
    sw_stat   = software_mode & (st_reg.setup[PRCD_STAT_BIT]
                               | st_reg.setup[PRCD_CRC_BIT]);

    st_next.fault    = st_reg.fault | selftest_fault_in;
    st_next.os_eff   = software_mode
                       ? st_reg.setup[PRCD_OSR_HI:PRCD_OSR_LO]
                       : PRCD_OSR_OFF;
    st_next.burst_eff = sw_burst;
    st_next.seq_eff   = sw_seq;
    st_next.stat_eff  = sw_stat;
    st_next.start     = 1'b0;
    st_next.init      = 1'b1;

    // Layers take their reset pairs on the first edge after release.
    if (!st_reg.init) begin
      st_next.stack = stack_init;
    end

    // Command decode.
    if (cmd_write) begin
      if (wr_flag) begin
        if (sel_stack) begin
          st_next.stack[sel_low] = wdata;
        end else if (sel_low == PRCD_SEL_SETUP) begin
          st_next.setup = wdata[PRCD_FAULT_BIT-1:0];
        end
      end else begin
        st_next.rd_stack = sel_stack;
        st_next.rd_sel   = sel_low;
        st_next.res_mode = !sel_stack
                           && (sel_low == PRCD_SEL_RESULTS);
        st_next.rd_ptr   = 7'h00;
      end
    end

    // Readback word for the current pointer.
    if (st_reg.res_mode) begin
      if (st_reg.rd_ptr < nwords) begin
        word = st_reg.rd_ptr[0]
               ? st_reg.res[st_reg.rd_ptr[5:1]][15:0]
               : st_reg.res[st_reg.rd_ptr[5:1]][31:16];
      end else if (st_reg.rd_ptr == nwords && st_reg.stat_eff) begin
        word = {st_reg.last_pair, st_reg.crc};
      end
    end else if (st_reg.rd_stack) begin
      word = {1'b0, 1'b1, st_reg.rd_sel, st_reg.stack[st_reg.rd_sel]};
    end else if (st_reg.rd_sel == PRCD_SEL_SETUP) begin
      word = {1'b0, 1'b0, PRCD_SEL_SETUP, 1'b0, st_reg.fault,
              st_reg.setup};
    end else if (st_reg.rd_sel == PRCD_SEL_STATUS) begin
      word = {st_reg.last_pair, st_reg.crc};
    end

    st_next.rd_prev = read_active;
    st_next.oe      = read_active;
    if (read_active && !st_reg.rd_prev) begin
      st_next.dout = word;
      if (st_reg.res_mode) begin
        st_next.rd_ptr = st_reg.rd_ptr + 7'h01;
      end
    end

    // Conversion control.
    unique case (st_reg.conv)
      PRCD_IDLE: begin
        if (conversion_trigger) begin
          st_next.cnt    = 6'h00;
          st_next.crc    = PRCD_CRC_SEED;
          st_next.rd_ptr = 7'h00;
          if (!sw_seq || sw_burst) begin
            st_next.layer = 5'h00;
          end
          st_next.conv = PRCD_START;
        end
      end
      PRCD_START: begin
        st_next.pair  = sw_seq ? cur_layer[7:0] : manual_pair;
        st_next.start = 1'b1;
        st_next.conv  = PRCD_WAIT;
      end
      PRCD_WAIT: begin
        if (conv_done) begin
          st_next.res[st_reg.cnt[4:0]] = {result_a, result_b};
          st_next.cnt       = st_reg.cnt + 6'h01;
          st_next.crc       = crc_new;
          st_next.last_pair = st_reg.pair;
          if (sw_seq) begin
            st_next.layer = (cur_layer[PRCD_LAST_BIT]
                             || st_reg.layer == 5'(LAYERS - 1))
                            ? 5'h00 : st_reg.layer + 5'h01;
          end
          if (sw_seq && sw_burst && !cur_layer[PRCD_LAST_BIT]
              && st_reg.layer != 5'(LAYERS - 1)) begin
            st_next.conv = PRCD_START;
          end else begin
            st_next.conv = PRCD_IDLE;
          end
        end
      end
    endcase
    st_next.busy = st_next.conv != PRCD_IDLE;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg           <= '0;
      st_reg.setup     <= PRCD_SETUP_RESET;
      st_reg.conv      <= PRCD_IDLE;
      st_reg.crc       <= PRCD_CRC_SEED;
    end else begin
      st_reg <= st_next;
    end
  end

  assign data_lines_out       = st_reg.dout;
  assign data_lines_oe        = st_reg.oe;
  assign conv_start           = st_reg.start;
  assign conv_pair            = st_reg.pair;
  assign conv_busy            = st_reg.busy;
  assign oversample_ratio     = st_reg.os_eff;
  assign burst_enable         = st_reg.burst_eff;
  assign sequencer_enable     = st_reg.seq_eff;
  assign status_append_enable = st_reg.stat_eff;
  assign selftest_fault_flag  = st_reg.fault;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_SETUP_WRITE: assert property (@(posedge clk) disable iff (rst)
    cmd_write && data_lines_in[15] && !data_lines_in[14]
    && data_lines_in[13:9] == PRCD_SEL_SETUP
    |=> st_reg.setup == $past(data_lines_in[6:0]))
    else $error("setup write not stored");
  AST_STACK_WRITE: assert property (@(posedge clk) disable iff (rst)
    cmd_write && data_lines_in[15] && data_lines_in[14]
    |=> st_reg.stack[$past(data_lines_in[13:9])]
        == $past(data_lines_in[8:0]))
    else $error("stack write not stored");
  AST_NO_WRITE: assert property (@(posedge clk) disable iff (rst)
    cmd_write && data_lines_in[15] && !data_lines_in[14]
    && data_lines_in[13:9] != PRCD_SEL_SETUP && st_reg.init
    |=> $stable(st_reg.setup) && $stable(st_reg.stack))
    else $error("unlisted write changed a register");
  AST_RESULT_MODE: assert property (@(posedge clk) disable iff (rst)
    cmd_write && data_lines_in[15:9] == 7'h00 |=> st_reg.res_mode)
    else $error("result readback not armed");
  AST_FAULT: assert property (@(posedge clk) disable iff (rst)
    selftest_fault_in |=> selftest_fault_flag [*3])
    else $error("fault flag not held");
  AST_SINGLE: assert property (@(posedge clk) disable iff (rst)
    st_reg.conv == PRCD_WAIT && conv_done && !st_reg.burst_eff
    && !(software_mode && st_reg.setup[6])
    |=> !conv_busy ##1 !conv_start)
    else $error("extra conversion without burst");
  AST_BURST: assert property (@(posedge clk) disable iff (rst)
    st_reg.conv == PRCD_WAIT && conv_done && software_mode
    && st_reg.setup[6] && st_reg.setup[5]
    && !st_reg.stack[st_reg.layer][8] && st_reg.layer != 5'h1f
    |=> ##1 conv_start)
    else $error("burst did not continue");
  AST_SW_MODE: assert property (@(posedge clk) disable iff (rst)
    !software_mode |=> !burst_enable && !sequencer_enable
    && !status_append_enable && oversample_ratio == PRCD_OSR_OFF)
    else $error("setup acted outside software mode");
  AST_STATUS: assert property (@(posedge clk) disable iff (rst)
    read_active && !st_reg.rd_prev && st_reg.res_mode
    && st_reg.stat_eff && st_reg.rd_ptr == {st_reg.cnt, 1'b0}
    |=> data_lines_out == {st_reg.last_pair, st_reg.crc})
    else $error("status word missing after results");

endmodule
`default_nettype wire

//--- hdl/prcd_pkg.sv
// Constants and types shared by the parallel register command decoder.
// Assumes a single system clock and an active-high asynchronous reset.
package prcd_pkg;

  // ****************************************************************
  // Command word layout
  // ****************************************************************
  localparam int unsigned PRCD_WORD_W    = 16;
  localparam int unsigned PRCD_WR_BIT    = 15;
  localparam int unsigned PRCD_SEL_HI    = 14;
  localparam int unsigned PRCD_SEL_LO    = 9;
  localparam int unsigned PRCD_STACK_BIT = 14;
  localparam int unsigned PRCD_DATA_W    = 9;
  localparam int unsigned PRCD_SEL_W     = 6;
  localparam int unsigned PRCD_IDX_W     = 5;

  // ****************************************************************
  // Register select codes
  // ****************************************************************
  localparam logic [4:0] PRCD_SEL_RESULTS = 5'h00;
  localparam logic [4:0] PRCD_SEL_SETUP   = 5'h02;
  localparam logic [4:0] PRCD_SEL_STATUS  = 5'h08;

  // ****************************************************************
  // Device setup register fields
  // ****************************************************************
  localparam logic [6:0] PRCD_SETUP_RESET = 7'h00;
  localparam int unsigned PRCD_FAULT_BIT  = 7;
  localparam int unsigned PRCD_BURST_BIT  = 6;
  localparam int unsigned PRCD_SEQ_BIT    = 5;
  localparam int unsigned PRCD_OSR_HI     = 4;
  localparam int unsigned PRCD_OSR_LO     = 2;
  localparam int unsigned PRCD_STAT_BIT   = 1;
  localparam int unsigned PRCD_CRC_BIT    = 0;
  localparam logic [2:0] PRCD_OSR_OFF     = 3'h0;

  // ****************************************************************
  // Sequencer stack layer fields
  // ****************************************************************
  localparam int unsigned PRCD_LAST_BIT   = 8;
  localparam int unsigned PRCD_LAYERS     = 32;
  localparam int unsigned PRCD_INIT_PAIRS = 8;
  localparam logic [8:0] PRCD_LAYER_ZERO  = 9'h000;
  localparam logic [7:0] PRCD_CRC_SEED    = 8'h00;

  // Conversion control states, Gray coded along idle, start, wait.
  typedef enum logic [1:0] {
    PRCD_IDLE  = 2'h0,
    PRCD_START = 2'h1,
    PRCD_WAIT  = 2'h3
  } prcd_conv_e;

endpackage

//--- hdl/prcd_crc_pair.sv
// CRC update over one converted channel pair, A word first, then B.
// Assumes both result words are stable while the caller samples crc_out.
`timescale 1ns/1ps
`default_nettype none
module prcd_crc_pair
  import prcd_pkg::*;
(
  input  wire logic [7:0]  crc_in,
  input  wire logic [15:0] data_a,
  input  wire logic [15:0] data_b,
  output logic      [7:0]  crc_out
);

  // ****************************************************************
  // One word step of the checksum
  // ****************************************************************
  function automatic logic [7:0] prcd_step(input logic [15:0] d,
                                          input logic [7:0]  c);
    logic [7:0] o;
    o[0] = d[14]^d[12]^d[8]^d[7]^d[6]^d[0]^c[0]^c[4]^c[6];
    o[1] = d[15]^d[14]^d[13]^d[12]^d[9]^d[6]^d[1]^d[0]^c[1]^c[4]
           ^c[5]^c[6]^c[7];
    o[2] = d[15]^d[13]^d[12]^d[10]^d[8]^d[6]^d[2]^d[1]^d[0]^c[0]
           ^c[2]^c[4]^c[5]^c[7];
    o[3] = d[14]^d[13]^d[11]^d[9]^d[7]^d[3]^d[2]^d[1]^c[1]^c[3]
           ^c[5]^c[6];
    o[4] = d[15]^d[14]^d[12]^d[10]^d[8]^d[4]^d[3]^d[2]^c[0]^c[2]
           ^c[4]^c[6]^c[7];
    o[5] = d[15]^d[13]^d[11]^d[9]^d[5]^d[4]^d[3]^c[1]^c[3]^c[5]^c[7];
    o[6] = d[14]^d[12]^d[10]^d[6]^d[5]^d[4]^c[2]^c[4]^c[6];
    o[7] = d[15]^d[13]^d[11]^d[7]^d[6]^d[5]^c[3]^c[5]^c[7];
    return o;
  endfunction

  always_comb begin
    crc_out = prcd_step(data_b, prcd_step(data_a, crc_in));
  end

endmodule
`default_nettype wire

//--- hdl/prcd_unused_placeholder.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- testbench/prcd_host_model.sv
// Host controller model that drives commands and reads on the data lines.
// Assumes the decoder samples every input on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module prcd_host_model
  import prcd_pkg::*;
(
  input  wire logic        clk,
  output logic             cmd_write,
  output logic      [15:0] data_lines_in,
  output logic             read_active,
  input  wire logic [15:0] data_lines_out,
  input  wire logic        data_lines_oe
);
  initial begin
    cmd_write     = 1'b0;
    data_lines_in = 16'h0000;
    read_active   = 1'b0;
  end

  // Sends one command word with a single-cycle strobe.
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    cmd_write     <= 1'b1;
    data_lines_in <= w;
    @(posedge clk);
    cmd_write     <= 1'b0;
    data_lines_in <= ~w;
  endtask

  // Raises read once, takes the word and the enable, then releases.
  task automatic fetch(output logic [15:0] w, output logic oe);
    @(posedge clk);
    read_active <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    w  = data_lines_out;
    oe = data_lines_oe;
    @(posedge clk);
    read_active <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the command decoder with a converter stub.
// Assumes the host model file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import prcd_pkg::*;
  localparam logic [23:0] CRC_M [8] = '{24'h51c151, 24'hf243f2,
    24'hb547b5, 24'h6a8e6a, 24'hd51cd5, 24'haa38aa, 24'h547054, 24'ha8e0a8};
  logic        clk = 1'b0;
  logic        rst, software_mode, selftest_fault_in, conversion_trigger;
  logic        conv_done, conv_start, conv_busy, data_lines_oe;
  logic [7:0]  manual_pair, conv_pair;
  logic [15:0] result_a, result_b, data_lines_out, w;
  logic [2:0]  oversample_ratio;
  logic        burst_enable, sequencer_enable, status_append_enable;
  logic        selftest_fault_flag;
  wire logic        cmd_write, read_active;
  wire logic [15:0] data_lines_in;
  logic [8:0]  d, lay [4];
  logic [7:0]  crc, seen [$];
  logic [15:0] aq [$], bq [$], eq [$];
  int          num_errors = 0;
  int          tests_run = 0;

  always #2.5 clk = ~clk;

  prcd_decoder i_prcd_decoder (.clk(clk), .rst(rst), .cmd_write(cmd_write),
    .data_lines_in(data_lines_in), .read_active(read_active),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .software_mode(software_mode), .selftest_fault_in(selftest_fault_in),
    .manual_pair(manual_pair), .conversion_trigger(conversion_trigger),
    .conv_done(conv_done), .result_a(result_a), .result_b(result_b),
    .conv_start(conv_start), .conv_pair(conv_pair), .conv_busy(conv_busy),
    .oversample_ratio(oversample_ratio), .burst_enable(burst_enable),
    .sequencer_enable(sequencer_enable),
    .status_append_enable(status_append_enable),
    .selftest_fault_flag(selftest_fault_flag));

  prcd_host_model i_prcd_host_model (.clk(clk), .cmd_write(cmd_write),
    .data_lines_in(data_lines_in), .read_active(read_active),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] crc_next(input logic [15:0] x,
                                          input logic [7:0] c);
    for (int i = 0; i < 8; i++) crc_next[i] = ^({x, c} & CRC_M[i]);
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] x);
    i_prcd_host_model.send(x);
  endtask

  task automatic rd(input logic [5:0] sel, output logic [15:0] x);
    logic oe;
    i_prcd_host_model.send({1'b0, sel, 9'h000});
    i_prcd_host_model.fetch(x, oe);
    check({15'h0, oe}, 16'h0001);
  endtask

  task automatic trig();
    @(posedge clk);
    conversion_trigger <= 1'b1;
    @(posedge clk);
    conversion_trigger <= 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    #1;
    while (conv_busy !== 1'b0 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({15'h0, conv_busy}, 16'h0000);
  endtask

  // Converter stub answers each start after a random delay.
  initial begin
    conv_done = 1'b0;
    result_a  = 16'h0000;
    result_b  = 16'h0000;
    forever begin
      @(posedge clk);
      if (conv_start === 1'b1) begin
        seen.push_back(conv_pair);
        repeat ($urandom_range(1, 4)) @(posedge clk);
        aq.push_back(16'($urandom));
        bq.push_back(16'($urandom));
        conv_done <= 1'b1;
        result_a  <= aq[$];
        result_b  <= bq[$];
        @(posedge clk);
        conv_done <= 1'b0;
      end
    end
  end

  initial begin
    #50us;
    num_errors++;
    tally_and_finish();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(4));
    rst                = 1'b1;
    software_mode      = 1'b0;
    selftest_fault_in  = 1'b0;
    manual_pair        = 8'h00;
    conversion_trigger = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(6'h02, w);
    check(w, 16'h0400);
    @(posedge clk);
    software_mode <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 9'h1ff : 9'($urandom);
      wr({7'h42, d});
      repeat (2) @(posedge clk);
      #1;
      check({12'h0, oversample_ratio, burst_enable}, {12'h0, d[4:2], d[6]});
      check({14'h0, sequencer_enable, status_append_enable},
            {14'h0, d[5], |d[1:0]});
      rd(6'h02, w);
      check(w, {7'h02, 2'b00, d[6:0]});
    end
    @(posedge clk);
    software_mode <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({10'h0, oversample_ratio, burst_enable, sequencer_enable,
           status_append_enable}, 16'h0000);
    @(posedge clk);
    software_mode <= 1'b1;
    for (int j = 0; j < 32; j++) if (j != 2) wr({2'b10, 5'(j), 9'h1ff});
    rd(6'h02, w);
    check(w, {7'h02, 2'b00, d[6:0]});
    rd(6'h01, w);
    check(w, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      lay[k] = {k == 2, 8'($urandom)};
      wr({2'b11, 5'(k), lay[k]});
    end
    rd(6'h21, w);
    check(w, {2'b01, 5'd1, lay[1]});
    rd(6'h25, w);
    check(w, {2'b01, 5'd5, 1'b0, 4'd5, 4'd5});
    wr({7'h42, 9'h061});
    seen.delete();
    aq.delete();
    bq.delete();
    trig();
    wait_idle();
    check(16'(seen.size()), 16'd3);
    crc = 8'h00;
    for (int k = 0; k < 3; k++) begin
      check({8'h0, seen[k]}, {8'h0, lay[k][7:0]});
      crc = crc_next(bq[k], crc_next(aq[k], crc));
      eq.push_back(aq[k]);
      eq.push_back(bq[k]);
    end
    eq.push_back({lay[2][7:0], crc});
    eq.push_back(16'h0000);
    rd(6'h00, w);
    check(w, eq[0]);
    for (int k = 1; k < 8; k++) begin
      i_prcd_host_model.fetch(w, d[0]);
      check(w, eq[k]);
    end
    rd(6'h08, w);
    check(w, {lay[2][7:0], crc});
    wr({7'h42, 9'h020});
    seen.delete();
    trig();
    trig();
    wait_idle();
    check(16'(seen.size()), 16'd1);
    check({8'h0, seen[0]}, {8'h0, lay[0][7:0]});
    wr({7'h42, 9'h000});
    @(posedge clk);
    manual_pair <= 8'($urandom);
    seen.delete();
    trig();
    wait_idle();
    check({8'h0, seen[0]}, {8'h0, manual_pair});
    @(posedge clk);
    selftest_fault_in <= 1'b1;
    @(posedge clk);
    selftest_fault_in <= 1'b0;
    wr({7'h42, 9'h000});
    rd(6'h02, w);
    check(w, 16'h0480);
    check({15'h0, selftest_fault_flag}, 16'h0001);
    tally_and_finish();
  end
endmodule
`default_nettype wire
